// ==== dv/aias_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// Host end of the sample stream; stalls on request
module aias_host_model (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic stall,
  input wire logic xfer_valid,
  input wire logic xfer_block_end,
  output var logic xfer_ready,
  output var int words,
  output var int blocks
);
  // Word taken only when valid and ready meet at an edge
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      xfer_ready <= 1'b0;
      words <= 0;
      blocks <= 0;
    end else begin
      xfer_ready <= !stall;
      if (xfer_valid && xfer_ready) begin
        words <= words + 1;
        blocks <= blocks + int'(xfer_block_end);
      end
    end
  end
endmodule
`default_nettype wire

// ==== dv/aias_seq_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
// Watches the sequencer's ports for timing relations
module aias_seq_properties #(
  parameter CHW = 7,
  parameter GW = 3,
  parameter DW = 16
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic continuous,
  input wire logic [1:0] xfer_mode,
  input wire logic xfer_ready,
  input wire logic err_clear,
  input wire logic [CHW-1:0] mux_chan,
  input wire logic [GW-1:0] programmable_gain_amp,
  input wire logic [1:0] term_mode,
  input wire logic conv_start,
  input wire logic running,
  input wire logic done,
  input wire logic ref_armed,
  input wire logic fifo_ovf_err,
  input wire logic host_ovf_err,
  input wire logic [DW-1:0] xfer_data,
  input wire logic xfer_valid,
  input wire logic xfer_block_end,
  input wire logic xfer_irq,
  input wire logic direct_valid
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  entry_setup_a: assert property (
    conv_start |-> $stable(mux_chan) && $stable(programmable_gain_amp) && $stable(term_mode))
    else $error("entry settings moved at conversion start");
  conv_pulse_a: assert property (conv_start |=> !conv_start)
    else $error("conversion start longer than one cycle");
  ref_blocked_a: assert property (continuous [*2] |-> !ref_armed)
    else $error("reference trigger armed in continuous mode");
  finish_stop_a: assert property ($rose(done) |=> !running)
    else $error("still running after done");
  xfer_hold_a: assert property (xfer_valid && !xfer_ready |=> xfer_valid && $stable(xfer_data))
    else $error("stream word dropped during stall");
  block_tag_a: assert property (xfer_block_end |-> xfer_valid)
    else $error("block end without valid word");
  irq_mode_a: assert property (xfer_irq |-> xfer_mode == 2'h1 ##1 !xfer_irq)
    else $error("interrupt pulse outside interrupt mode");
  fifo_err_a: assert property (fifo_ovf_err && !err_clear |=> fifo_ovf_err)
    else $error("fifo overflow flag lost");
  host_err_a: assert property (!continuous && !host_ovf_err |=> !host_ovf_err)
    else $error("host overflow flagged in finite mode");
  direct_pulse_a: assert property (direct_valid |-> xfer_mode == 2'h2 ##1 !direct_valid)
    else $error("direct read answer malformed");
endmodule
bind aias_seq aias_seq_properties #(.CHW(CHW), .GW(GW), .DW(DW)) i_aias_seq_properties (
  .mclk, .rst_n, .continuous, .xfer_mode, .xfer_ready, .err_clear, .mux_chan,
  .programmable_gain_amp, .term_mode, .conv_start, .running, .done, .ref_armed,
  .fifo_ovf_err, .host_ovf_err, .xfer_data, .xfer_valid, .xfer_block_end, .xfer_irq,
  .direct_valid
);
`default_nettype wire

// ==== dv/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic mclk, rst_n, hw_timed, continuous, ext_pace_sel, ext_pacing_clk, sw_convert;
  logic host_start, host_stop, ref_trig_en, start_trig, conv_done, host_buf_overrun;
  logic host_read, xfer_ready, err_clear, stall, conv_start, running, done, ref_armed;
  logic ref_seen, fifo_ovf_err, host_ovf_err, xfer_valid, xfer_block_end, xfer_irq;
  logic direct_valid, ref_trig, pause_trig;
  logic [15:0] pace_div, xfer_data, direct_data, last_word;
  logic [15:0] conv_data = 16'h0000;
  logic [1:0] xfer_mode, scan_len_m1, term_mode;
  logic [6:0] mux_chan;
  logic [2:0] programmable_gain_amp;
  logic [23:0] sample_total;
  logic [27:0] entry_chan;
  logic [11:0] entry_gain;
  logic [7:0] entry_term;
  int n_errors, num_checks, words, blocks, b;
  int n_conv = 0, cyc = 0, cd = 0, n_irq = 0;
  aias_seq i_aias_seq (
    .mclk, .rst_n, .ce(1'b1), .hw_timed, .continuous, .ext_pace_sel, .pace_div,
    .ext_pacing_clk, .xfer_mode, .scan_len_m1, .entry_chan, .entry_gain, .entry_term,
    .sample_total, .sw_convert, .host_start, .host_stop, .ref_trig_en, .start_trig,
    .ref_trig, .pause_trig, .conv_done, .conv_data, .host_buf_overrun,
    .host_read, .xfer_ready, .err_clear, .mux_chan, .programmable_gain_amp, .term_mode,
    .conv_start, .running, .done, .ref_armed, .ref_seen, .fifo_ovf_err, .host_ovf_err,
    .xfer_data, .xfer_valid, .xfer_block_end, .xfer_irq, .direct_data, .direct_valid
  );
  aias_host_model i_aias_host_model (
    .mclk, .rst_n, .stall, .xfer_valid, .xfer_block_end, .xfer_ready, .words, .blocks
  );
  // Clock at 25 ns period
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // Converter answers four cycles after each start; stream monitor; cycle ceiling
  always @(posedge mclk) begin
    conv_done <= 1'b0;
    if (cd == 1) begin
      conv_done <= 1'b1;
      conv_data <= conv_data + 16'h0001;
    end
    cd <= (conv_start === 1'b1) ? 4 : (cd > 0 ? cd - 1 : 0);
    n_conv <= n_conv + int'(conv_start === 1'b1);
    n_irq <= n_irq + int'(xfer_irq === 1'b1);
    if (xfer_valid === 1'b1 && xfer_ready === 1'b1) begin
      last_word <= xfer_data;
    end
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_errors++;
      close_out;
    end
  end
  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic pulse(ref logic s);
    @(negedge mclk);
    s = 1'b1;
    @(negedge mclk);
    s = 1'b0;
  endtask
  task automatic wait_for(ref logic s, output logic ok);
    ok = 1'b0;
    for (int i = 0; i < 40 && !ok; i++) begin
      @(posedge mclk);
      #1 ok = (s === 1'b1);
    end
  endtask
  // Software timing over six conversions, wrapping the scan list
  task automatic t_sw;
    logic ok;
    int e;
    hw_timed = 1'b0;
    start_trig = 1'b1;
    pulse(host_start);
    b = n_conv;
    repeat (30) @(negedge mclk);
    chk("idle conversions", b, n_conv);
    for (int k = 0; k < 6; k++) begin
      pulse(sw_convert);
      wait_for(conv_start, ok);
      e = k % 4;
      chk("conv_start", 1, ok);
      chk("mux_chan", 16 + e, mux_chan);
      chk("gain", 7 - e, programmable_gain_amp);
      chk("term_mode", entry_term[e*2 +: 2], term_mode);
      repeat (10) @(negedge mclk);
    end
    chk("conversions", b + 6, n_conv);
    chk("done", 1, done);
    chk("running", 0, running);
    $display("test software timing ended");
  endtask
  // Continuous paced run with host stall, overflow, blocks and stop
  task automatic t_hw;
    hw_timed = 1'b1;
    continuous = 1'b1;
    xfer_mode = 2'h1;
    ref_trig_en = 1'b1;
    ref_trig = 1'b1;
    stall = 1'b1;
    pulse(host_start);
    b = n_conv;
    repeat (400) @(negedge mclk);
    chk("paced conversions", 1, n_conv - b >= 30);
    chk("ref_armed", 0, ref_armed);
    chk("ref_seen", 0, ref_seen);
    chk("fifo_ovf_err", 1, fifo_ovf_err);
    stall = 1'b0;
    repeat (300) @(negedge mclk);
    chk("blocks", 1, blocks >= 1);
    pulse(host_buf_overrun);
    repeat (4) @(negedge mclk);
    chk("host_ovf_err", 1, host_ovf_err);
    chk("running", 1, running);
    pulse(host_stop);
    repeat (60) @(negedge mclk);
    chk("stopped", 0, running);
    chk("irq pulses", blocks, n_irq);
    pulse(err_clear);
    repeat (3) @(negedge mclk);
    chk("cleared", 0, {fifo_ovf_err, host_ovf_err});
    ref_trig = 1'b0;
    $display("test continuous run ended");
  endtask
  // Internal pacing by DMA: pause holds off ticks, reference trigger seen, three samples
  task automatic t_dma;
    int d0, w0;
    continuous = 1'b0;
    ext_pace_sel = 1'b0;
    xfer_mode = 2'h0;
    sample_total = 24'h000003;
    pause_trig = 1'b1;
    pulse(host_start);
    b = n_conv;
    d0 = int'(conv_data);
    w0 = words;
    repeat (50) @(negedge mclk);
    chk("paused conversions", b, n_conv);
    chk("ref_armed", 1, ref_armed);
    pause_trig = 1'b0;
    ref_trig = 1'b1;
    repeat (80) @(negedge mclk);
    chk("ref_seen", 1, ref_seen);
    chk("finite conversions", b + 3, n_conv);
    chk("done", 1, done);
    chk("stream words", w0 + 3, words);
    chk("last stream word", d0 + 3, last_word);
    ref_trig = 1'b0;
    $display("test dma transfer ended");
  endtask
  // External pacing, finite count of three, direct read of the first word
  task automatic t_ext;
    logic ok;
    int d0;
    continuous = 1'b0;
    ext_pace_sel = 1'b1;
    xfer_mode = 2'h2;
    sample_total = 24'h000003;
    pulse(host_start);
    b = n_conv;
    d0 = int'(conv_data);
    repeat (3) begin
      repeat (6) @(negedge mclk);
      ext_pacing_clk = 1'b1;
      repeat (6) @(negedge mclk);
      ext_pacing_clk = 1'b0;
    end
    repeat (20) @(negedge mclk);
    chk("external conversions", b + 3, n_conv);
    chk("done", 1, done);
    pulse(host_read);
    wait_for(direct_valid, ok);
    chk("direct_valid", 1, ok);
    chk("direct_data", d0 + 1, direct_data);
    $display("test external pacing ended");
  endtask
  task close_out;
    $display("comparisons %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    {rst_n, hw_timed, continuous, ext_pace_sel, ext_pacing_clk, sw_convert} = '0;
    {host_start, host_stop, ref_trig_en, start_trig, host_buf_overrun} = '0;
    {host_read, err_clear, stall, ref_trig, pause_trig, xfer_mode} = '0;
    {n_errors, num_checks, b} = '0;
    pace_div = 16'h0009;
    scan_len_m1 = 2'h3;
    sample_total = 24'h000006;
    entry_chan = {7'h13, 7'h12, 7'h11, 7'h10};
    entry_gain = {3'h4, 3'h5, 3'h6, 3'h7};
    entry_term = {2'h0, 2'h2, 2'h1, 2'h0};
    repeat (3) @(negedge mclk);
    rst_n = 1'b1;
    repeat (4) @(negedge mclk);
    t_sw;
    t_hw;
    t_dma;
    t_ext;
    close_out;
  end
endmodule
`default_nettype wire

// ==== hw/aias_defs.vh ====
`ifndef AIAS_DEFS_VH
`define AIAS_DEFS_VH
// ----------------------------------------
// Timing, modes and encodings
// ----------------------------------------
`define AIAS_CLK_HZ 40000000
`define AIAS_TERM_PAIRED 2'h0
`define AIAS_TERM_REF_SINGLE 2'h1
`define AIAS_TERM_NONREF_SINGLE 2'h2
`define AIAS_XFER_DMA 2'h0
`define AIAS_XFER_IRQ 2'h1
`define AIAS_XFER_DIRECT 2'h2
`define AIAS_ST_IDLE 3'h0
`define AIAS_ST_ARMED 3'h1
`define AIAS_ST_GAIN 3'h2
`define AIAS_ST_CONV 3'h3
`define AIAS_ST_WAIT 3'h4
`define AIAS_BLOCK_WORDS 8'h10
`define AIAS_PACE_DIV_RST 16'h0028
`define AIAS_FIFO_DEPTH_LOG2 4
`endif

// ==== hw/aias_fifo.v ====
`timescale 1ns/1ps
`default_nettype none
// Sample FIFO; on overflow the oldest word is dropped so new data overwrites it
module aias_fifo #(
  parameter W = 16,
  parameter AW = 4
) (
  input wire clk,
  input wire rst,
  input wire ce,
  input wire wr_en,
  input wire [W-1:0] wr_data,
  input wire rd_en,
  output reg [W-1:0] rd_data,
  output reg rd_valid,
  output wire full,
  output wire empty,
  output wire [AW:0] level,
  output reg ovf_pulse
);
  reg [W-1:0] mem [0:(1<<AW)-1];
  reg [AW:0] wp_reg;
  reg [AW:0] rp_reg;
  wire do_rd;
  wire drop;
  assign level = wp_reg - rp_reg;
  assign full = (level == (1 << AW));
  assign empty = (level == {(AW+1){1'b0}});
  assign drop = wr_en & full & ~do_rd; // A read in the same cycle frees a slot
  assign do_rd = rd_en & ~empty;
  // ----------------------------------------
  // Storage and pointers
  // ----------------------------------------
  always @(posedge clk) begin
    if (ce && wr_en) begin
      mem[wp_reg[AW-1:0]] <= wr_data;
    end
  end
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wp_reg <= {(AW+1){1'b0}};
      rp_reg <= {(AW+1){1'b0}};
      rd_data <= {W{1'b0}};
      rd_valid <= 1'b0;
      ovf_pulse <= 1'b0;
    end else if (ce) begin
      ovf_pulse <= drop;
      rd_valid <= do_rd & ~drop;
      if (wr_en) begin
        wp_reg <= wp_reg + 1'b1;
      end
      // Overwrite discards oldest word
      if (drop || do_rd) begin
        rp_reg <= rp_reg + 1'b1;
      end
      if (do_rd) begin
        rd_data <= mem[rp_reg[AW-1:0]];
      end
    end
  end
endmodule
`default_nettype wire

// ==== hw/aias_seq.v ====
`timescale 1ns/1ps
`default_nettype none
`include "aias_defs.vh"
module aias_seq #(
  parameter NENT = 4,
  parameter EW = 2,
  parameter CHW = 7,
  parameter GW = 3,
  parameter DW = 16,
  parameter CNTW = 24,
  parameter USB_VARIANT = 0
) (
  input wire mclk,
  input wire rst_n,
  input wire ce,
  input wire hw_timed,
  input wire continuous,
  input wire ext_pace_sel,
  input wire [15:0] pace_div,
  input wire ext_pacing_clk,
  input wire [1:0] xfer_mode,
  input wire [EW-1:0] scan_len_m1,
  input wire [NENT*CHW-1:0] entry_chan,
  input wire [NENT*GW-1:0] entry_gain,
  input wire [NENT*2-1:0] entry_term,
  input wire [CNTW-1:0] sample_total,
  input wire sw_convert,
  input wire host_start,
  input wire host_stop,
  input wire ref_trig_en,
  input wire start_trig,
  input wire ref_trig,
  input wire pause_trig,
  input wire conv_done,
  input wire [DW-1:0] conv_data,
  input wire host_buf_overrun,
  input wire host_read,
  input wire xfer_ready,
  input wire err_clear,
  output reg [CHW-1:0] mux_chan,
  output reg [GW-1:0] programmable_gain_amp,
  output reg [1:0] term_mode,
  output reg conv_start,
  output reg running,
  output reg done,
  output reg ref_armed,
  output reg ref_seen,
  output reg fifo_ovf_err,
  output reg host_ovf_err,
  output reg [DW-1:0] xfer_data,
  output reg xfer_valid,
  output reg xfer_block_end,
  output reg xfer_irq,
  output reg [DW-1:0] direct_data,
  output reg direct_valid
);
  // ----------------------------------------
  // Reset release and pin synchronisers
  // ----------------------------------------
  reg [1:0] rst_sync_reg;
  wire rst;
  assign rst = ~rst_sync_reg[1];
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  reg [4:1] pin_s1_reg;
  reg [4:1] pin_s2_reg;
  reg ext_d_reg;
  // Pins from outside the clock domain take two flops
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      pin_s1_reg <= 4'h0;
      pin_s2_reg <= 4'h0;
      ext_d_reg <= 1'b0;
    end else if (ce) begin
      pin_s1_reg <= {pause_trig, ref_trig, start_trig, ext_pacing_clk};
      pin_s2_reg <= pin_s1_reg;
      ext_d_reg <= pin_s2_reg[1];
    end
  end
  wire ext_edge;
  wire st_trig_s;
  wire rf_trig_s;
  wire pz_trig_s;
  assign ext_edge = pin_s2_reg[1] & ~ext_d_reg;
  assign st_trig_s = pin_s2_reg[2];
  assign rf_trig_s = pin_s2_reg[3];
  assign pz_trig_s = pin_s2_reg[4];
  // ----------------------------------------
  // Scan pacing clock
  // ----------------------------------------
  reg [15:0] div_reg;
  wire int_tick;
  wire pace_tick;
  assign int_tick = (div_reg == 16'h0000);
  assign pace_tick = ext_pace_sel ? ext_edge : int_tick;
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      div_reg <= `AIAS_PACE_DIV_RST;
    end else if (ce) begin
      if (int_tick || !running) begin
        div_reg <= pace_div;
      end else begin
        div_reg <= div_reg - 16'h0001;
      end
    end
  end
  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  reg [2:0] st_reg;
  reg [EW-1:0] ent_reg;
  reg [CNTW-1:0] cnt_reg;
  reg pend_reg;
  wire sw_mode;
  wire eff_direct;
  wire is_last;
  wire go;
  assign sw_mode = ~hw_timed;
  // USB parts never take the direct path in hardware timing
  assign eff_direct = (xfer_mode == `AIAS_XFER_DIRECT) && !(USB_VARIANT != 0 && hw_timed);
  assign is_last = !continuous && (cnt_reg + 1'b1 >= sample_total);
  // Triggers gate only hardware-timed scans
  assign go = sw_mode ? sw_convert : (pace_tick & ~pz_trig_s);
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_reg <= `AIAS_ST_IDLE;
      ent_reg <= {EW{1'b0}};
      cnt_reg <= {CNTW{1'b0}};
      pend_reg <= 1'b0;
      running <= 1'b0;
      done <= 1'b0;
      ref_armed <= 1'b0;
      ref_seen <= 1'b0;
      conv_start <= 1'b0;
      mux_chan <= {CHW{1'b0}};
      programmable_gain_amp <= {GW{1'b0}};
      term_mode <= `AIAS_TERM_PAIRED;
    end else if (ce) begin
      conv_start <= 1'b0;
      if (sw_mode && sw_convert && st_reg != `AIAS_ST_IDLE) begin
        pend_reg <= 1'b1;
      end
      // Reference trigger only armed in finite mode
      if (ref_armed && hw_timed && rf_trig_s) begin
        ref_seen <= 1'b1;
      end
      case (st_reg)
        `AIAS_ST_IDLE: begin
          if (host_start) begin
            pend_reg <= 1'b0;
            done <= 1'b0;
            ref_seen <= 1'b0;
            cnt_reg <= {CNTW{1'b0}};
            ent_reg <= {EW{1'b0}};
            ref_armed <= ref_trig_en & ~continuous & hw_timed;
            running <= 1'b1;
            st_reg <= hw_timed ? `AIAS_ST_ARMED : `AIAS_ST_WAIT;
          end
        end
        `AIAS_ST_ARMED: begin
          if (st_trig_s) begin
            st_reg <= `AIAS_ST_WAIT;
          end
        end
        `AIAS_ST_WAIT: begin
          if (go || pend_reg) begin
            pend_reg <= 1'b0;
            mux_chan <= entry_chan[ent_reg*CHW +: CHW];
            programmable_gain_amp <= entry_gain[ent_reg*GW +: GW];
            term_mode <= entry_term[ent_reg*2 +: 2];
            st_reg <= `AIAS_ST_GAIN;
          end
        end
        `AIAS_ST_GAIN: begin
          conv_start <= 1'b1;
          st_reg <= `AIAS_ST_CONV;
        end
        `AIAS_ST_CONV: begin
          if (conv_done) begin
            cnt_reg <= cnt_reg + 1'b1;
            ent_reg <= (ent_reg == scan_len_m1) ? {EW{1'b0}} : ent_reg + 1'b1;
            if (is_last) begin
              done <= 1'b1;
              running <= 1'b0;
              ref_armed <= 1'b0;
              st_reg <= `AIAS_ST_IDLE;
            end else begin
              st_reg <= `AIAS_ST_WAIT;
            end
          end
        end
        default: begin
          st_reg <= `AIAS_ST_IDLE;
        end
      endcase
      // Explicit stop ends any mode
      if (host_stop) begin
        running <= 1'b0;
        ref_armed <= 1'b0;
        pend_reg <= 1'b0;
        st_reg <= `AIAS_ST_IDLE;
      end
    end
  end
  // ----------------------------------------
  // Sample FIFO
  // ----------------------------------------
  wire [DW-1:0] f_rd_data;
  wire f_rd_valid;
  wire f_ovf;
  wire f_rd_en;
  wire capture;
  reg [1:0] sk_cnt_reg;
  reg [DW-1:0] sk_a_reg;
  reg [DW-1:0] sk_b_reg;
  assign capture = (st_reg == `AIAS_ST_CONV) & conv_done;
  // Direct mode pulls on host_read; otherwise pull from FIFO only while the skid buffer is empty
  assign f_rd_en = eff_direct ? host_read : (sk_cnt_reg == 2'h0 && !f_rd_valid);
  aias_fifo #(
    .W(DW),
    .AW(`AIAS_FIFO_DEPTH_LOG2)
  ) u_fifo (
    .clk(mclk),
    .rst(rst),
    .ce(ce),
    .wr_en(capture),
    .wr_data(conv_data),
    .rd_en(f_rd_en),
    .rd_data(f_rd_data),
    .rd_valid(f_rd_valid),
    .full(),
    .empty(),
    .level(),
    .ovf_pulse(f_ovf)
  );
  // ----------------------------------------
  // Errors, set wins over clear
  // ----------------------------------------
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      fifo_ovf_err <= 1'b0;
      host_ovf_err <= 1'b0;
    end else if (ce) begin
      fifo_ovf_err <= f_ovf | (fifo_ovf_err & ~err_clear);
      host_ovf_err <= (host_buf_overrun & continuous) | (host_ovf_err & ~err_clear);
    end
  end
  // ----------------------------------------
  // Transfer path with two-entry buffer
  // ----------------------------------------
  reg [7:0] blk_reg;
  wire sk_push;
  wire sk_pop;
  assign sk_push = f_rd_valid & ~eff_direct;
  assign sk_pop = xfer_valid & xfer_ready;
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      sk_cnt_reg <= 2'h0;
      sk_a_reg <= {DW{1'b0}};
      sk_b_reg <= {DW{1'b0}};
      xfer_data <= {DW{1'b0}};
      xfer_valid <= 1'b0;
      xfer_block_end <= 1'b0;
      xfer_irq <= 1'b0;
      blk_reg <= 8'h00;
      direct_data <= {DW{1'b0}};
      direct_valid <= 1'b0;
    end else if (ce) begin
      // Direct reads, one sample per request
      direct_valid <= f_rd_valid & eff_direct;
      if (f_rd_valid && eff_direct) begin
        direct_data <= f_rd_data;
      end
      xfer_irq <= 1'b0;
      if (sk_pop) begin
        blk_reg <= xfer_block_end ? 8'h00 : blk_reg + 8'h01;
        if (xfer_block_end && xfer_mode == `AIAS_XFER_IRQ) begin
          xfer_irq <= 1'b1;
        end
      end
      case ({sk_push, sk_pop})
        2'b10: begin
          if (sk_cnt_reg == 2'h0) begin
            sk_a_reg <= f_rd_data;
          end else begin
            sk_b_reg <= f_rd_data;
          end
          sk_cnt_reg <= sk_cnt_reg + 2'h1;
        end
        2'b01: begin
          sk_a_reg <= sk_b_reg;
          sk_cnt_reg <= sk_cnt_reg - 2'h1;
        end
        2'b11: begin
          if (sk_cnt_reg == 2'h1) begin
            sk_a_reg <= f_rd_data;
          end else begin
            sk_a_reg <= sk_b_reg;
            sk_b_reg <= f_rd_data;
          end
        end
        default: begin
          sk_cnt_reg <= sk_cnt_reg;
        end
      endcase
      // Output stage mirrors head of buffer; block end only tags a shown word
      xfer_valid <= (sk_cnt_reg - (sk_pop ? 2'h1 : 2'h0)) != 2'h0 || sk_push;
      xfer_data <= sk_pop ? ((sk_cnt_reg == 2'h2) ? sk_b_reg : f_rd_data)
                          : ((sk_cnt_reg == 2'h0) ? f_rd_data : sk_a_reg);
      xfer_block_end <= (sk_pop ? blk_reg + 8'h01 : blk_reg) == (`AIAS_BLOCK_WORDS - 8'h01)
                        && !(sk_pop && xfer_block_end)
                        && ((sk_cnt_reg - (sk_pop ? 2'h1 : 2'h0)) != 2'h0 || sk_push);
    end
  end
endmodule
`default_nettype wire
